// *** poc_pkg.sv ***
package poc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VOL = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_GAIN = 8'h10;
  localparam logic [7:0] ADDR_OUT = 8'h14;

  // Control register fields
  localparam int CTRL_DEEMPH = 0;
  localparam int CTRL_SOFT_MUTE_CTRL = 2;
  localparam int CTRL_ALC = 3;
  localparam int CTRL_DAC_TO_LINEOUT = 4;
  localparam int CTRL_LOSAVE = 5;
  localparam int CTRL_LOPWR = 6;
  localparam int CTRL_MONOPWR = 7;
  localparam int CTRL_MIX = 8;
  localparam int CTRL_SHARE = 10;
  localparam int CTRL_ADCPWR = 11;
  localparam int CTRL_BEEPSPK = 12;
  localparam int CTRL_BEEPLO = 13;
  localparam int CTRL_BEEPRES = 14;
  localparam int CTRL_WIDTH = 15;

  // Volume register fields
  localparam int VOL_LEVEL = 0;
  localparam int VOL_LOGAIN = 8;
  localparam int VOL_BEEPLVL = 10;
  localparam int VOL_SPKGAIN = 13;
  localparam int VOL_WIDTH = 15;

  localparam logic [14:0] CTRL_RESET = 15'h0001;
  localparam logic [14:0] VOL_RESET = 15'h0091;

  //////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [1:0] DEEMPH_44K1 = 2'h0;
  localparam logic [1:0] DEEMPH_OFF = 2'h1;
  localparam logic [1:0] DEEMPH_48K = 2'h2;
  localparam logic [1:0] DEEMPH_32K = 2'h3;
  localparam logic [1:0] MIX_STEREO = 2'h0;
  localparam logic [1:0] MIX_LEFT = 2'h1;
  localparam logic [1:0] MIX_RIGHT = 2'h2;
  localparam logic [1:0] MIX_AVERAGE = 2'h3;
  localparam logic [7:0] VOL_MUTE = 8'h00;

  typedef enum logic [1:0] {
    POC_LO_DOWN = 2'b00,
    POC_LO_NORMAL = 2'b01,
    POC_LO_SAVE_FALL = 2'b10,
    POC_LO_SAVE_RISE = 2'b11
  } poc_lo_mode_t;

  //////////////////////////////////////////////////////////////////////////
  // Soft mute ramp, counted in sample periods
  localparam int MUTE_TIME_US = 10000;
  localparam int REF_FS_HZ = 44100;
  localparam int MUTE_STEPS_INT = MUTE_TIME_US * REF_FS_HZ / 1000000;
  localparam logic [8:0] MUTE_FULL = 9'(MUTE_STEPS_INT);
  localparam logic [15:0] MUTE_RECIP = 16'(65536 / MUTE_STEPS_INT);

  // De-emphasis 50/15 us shelf, bilinear, Q2.14; y = b0*x + b1*x1 + c*y1
  localparam int COEF_FRAC = 14;
  localparam logic signed [15:0] B0_44K1 = 16'sh1B7B;
  localparam logic signed [15:0] B1_44K1 = -16'sh03D2;
  localparam logic signed [15:0] C_44K1 = 16'sh2857;
  localparam logic signed [15:0] B0_48K = 16'sh1AED;
  localparam logic signed [15:0] B1_48K = -16'sh04DB;
  localparam logic signed [15:0] C_48K = 16'sh29EE;
  localparam logic signed [15:0] B0_32K = 16'sh1DDE;
  localparam logic signed [15:0] B1_32K = 16'sh009C;
  localparam logic signed [15:0] C_32K = 16'sh2186;

  //////////////////////////////////////////////////////////////////////////
  // Analog gains in hundredths of a dB
  localparam logic [11:0] SPK_ALC_BOOST = 12'h0C8;

  function automatic logic [11:0] poc_beep_atten(input logic [2:0] sel);
    case (sel)
      3'h0: poc_beep_atten = 12'h000;
      3'h1: poc_beep_atten = 12'h258;
      3'h2: poc_beep_atten = 12'h4B0;
      3'h3: poc_beep_atten = 12'h960;
      3'h4: poc_beep_atten = 12'hAF0;
      3'h5: poc_beep_atten = 12'hC80;
      3'h6: poc_beep_atten = 12'hE10;
      default: poc_beep_atten = 12'hFA0;
    endcase
  endfunction : poc_beep_atten

  function automatic logic [11:0] poc_lo_gain(input logic [1:0] sel);
    case (sel)
      2'h0: poc_lo_gain = 12'h000;
      2'h1: poc_lo_gain = 12'h086;
      2'h2: poc_lo_gain = 12'h0C8;
      default: poc_lo_gain = 12'h14E;
    endcase
  endfunction : poc_lo_gain

  function automatic logic [11:0] poc_spk_gain(input logic [1:0] sel);
    case (sel)
      2'h0: poc_spk_gain = 12'h262;
      2'h1: poc_spk_gain = 12'h32A;
      2'h2: poc_spk_gain = 12'h3F2;
      default: poc_spk_gain = 12'h4BA;
    endcase
  endfunction : poc_spk_gain

endpackage : poc_pkg

// *** poc_fifo.sv ***
`timescale 1ns/100ps
module poc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; a slot is only read as valid data after it has been written
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  property p_fifo_full;
    @(posedge pclk) disable iff (!presetn)
      (count == FULL_COUNT) && !pop |=> !in_ready && (count == FULL_COUNT);
  endproperty
  a_fifo_full: assert property (p_fifo_full)
    else $error("fifo accepted data while full");

endmodule : poc_fifo

// *** poc_output_ctrl.sv ***
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module poc_output_ctrl
  import poc_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample rate strobe
  input wire logic fs_tick,
  // Playback data
  output logic [SAMPLE_W-1:0] left_line_output,
  output logic [SAMPLE_W-1:0] right_line_output,
  output logic line_out_valid,
  // Analog controls
  output logic line_drive_en,
  output poc_pkg::poc_lo_mode_t lineout_mode,
  output logic [1:0] lineout_gain_sel,
  output logic [7:0] output_volume_two,
  output logic lineout_pullup_en,
  output logic mic_pullup_en,
  output logic right_line_output_mono_in_mode,
  output logic beep_spk_route,
  output logic beep_lo_route,
  output logic beep_ext_mode
);
  localparam int W = SAMPLE_W;
  localparam int PW = 2 * SAMPLE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [CTRL_WIDTH-1:0] ctrl, next_ctrl;
  logic [VOL_WIDTH-1:0] vol, next_vol;
  logic wr_en, rd_sel, data_sel, known_addr;
  logic fifo_in_ready, fifo_out_valid;
  logic [PW-1:0] fifo_out_data;
  logic [8:0] mute_level, next_mute_level;
  logic [1:0] deemph_select, channel_mix_sel;
  logic soft_mute_ctrl, auto_level_control, dac_to_lineout;
  logic lineout_save, lineout_power, mono_input_power;
  logic line_share_en, adc_power, beep_to_speaker, beep_to_lineout;
  logic beep_resistor_mode;
  logic [2:0] beep_level_sel;
  logic [1:0] speaker_gain_sel;
  logic signed [12:0] lo_beep_gain, spk_beep_gain;
  logic [11:0] beep_atten, spk_gain;

  assign deemph_select = ctrl[CTRL_DEEMPH +: 2];
  assign soft_mute_ctrl = ctrl[CTRL_SOFT_MUTE_CTRL];
  assign auto_level_control = ctrl[CTRL_ALC];
  assign dac_to_lineout = ctrl[CTRL_DAC_TO_LINEOUT];
  assign lineout_save = ctrl[CTRL_LOSAVE];
  assign lineout_power = ctrl[CTRL_LOPWR];
  assign mono_input_power = ctrl[CTRL_MONOPWR];
  assign channel_mix_sel = ctrl[CTRL_MIX +: 2];
  assign line_share_en = ctrl[CTRL_SHARE];
  assign adc_power = ctrl[CTRL_ADCPWR];
  assign beep_to_speaker = ctrl[CTRL_BEEPSPK];
  assign beep_to_lineout = ctrl[CTRL_BEEPLO];
  assign beep_resistor_mode = ctrl[CTRL_BEEPRES];
  assign output_volume_two = vol[VOL_LEVEL +: 8];
  assign lineout_gain_sel = vol[VOL_LOGAIN +: 2];
  assign beep_level_sel = vol[VOL_BEEPLVL +: 3];
  assign speaker_gain_sel = vol[VOL_SPKGAIN +: 2];

  assign data_sel = (paddr == ADDR_DATA);
  assign known_addr = (paddr == ADDR_CTRL) || (paddr == ADDR_VOL) ||
                      data_sel || (paddr == ADDR_STAT) ||
                      (paddr == ADDR_GAIN) || (paddr == ADDR_OUT);
  // A sample write waits for FIFO space instead of being dropped
  assign pready = !(psel && pwrite && data_sel) || fifo_in_ready;
  assign pslverr = psel && penable && !known_addr;
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_sel = psel && !pwrite;

  always_comb begin
    next_ctrl = ctrl;
    next_vol = vol;
    if (wr_en && (paddr == ADDR_CTRL)) begin
      next_ctrl = pwdata[CTRL_WIDTH-1:0];
    end
    if (wr_en && (paddr == ADDR_VOL)) begin
      next_vol = pwdata[VOL_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      vol <= VOL_RESET;
    end else begin
      ctrl <= next_ctrl;
      vol <= next_vol;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_sel) begin
      case (paddr)
        ADDR_CTRL: prdata = 32'(ctrl);
        ADDR_VOL: prdata = 32'(vol);
        ADDR_STAT: prdata = {17'h00000, (mute_level == 9'h000),
                             fifo_out_valid, !fifo_in_ready, line_drive_en,
                             lineout_mode, mute_level};
        ADDR_GAIN: prdata = {3'h0, spk_beep_gain, 3'h0, lo_beep_gain};
        ADDR_OUT: prdata = 32'({right_line_output, left_line_output});
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog path selection
  always_comb begin
    case ({lineout_save, lineout_power})
      2'b00: lineout_mode = POC_LO_DOWN;
      2'b01: lineout_mode = POC_LO_NORMAL;
      2'b10: lineout_mode = POC_LO_SAVE_FALL;
      2'b11: lineout_mode = POC_LO_SAVE_RISE;
      default: lineout_mode = POC_LO_DOWN;
    endcase
  end

  // Host pacing of save/power for pop reduction is left to software
  assign line_drive_en = !mono_input_power && lineout_power &&
                         dac_to_lineout;
  assign right_line_output_mono_in_mode = mono_input_power;
  assign lineout_pullup_en = line_share_en && lineout_save;
  assign mic_pullup_en = line_share_en && !adc_power;
  assign beep_spk_route = mono_input_power && beep_to_speaker;
  assign beep_lo_route = mono_input_power && beep_to_lineout;
  assign beep_ext_mode = beep_resistor_mode;

  // External resistor sets its own gain, so the level field drops out
  assign beep_atten = beep_resistor_mode ? 12'h000 :
                      poc_beep_atten(beep_level_sel);
  assign spk_gain = poc_spk_gain(speaker_gain_sel) +
                    (auto_level_control ? SPK_ALC_BOOST : 12'h000);
  assign lo_beep_gain = $signed({1'b0, poc_lo_gain(lineout_gain_sel)}) -
                        $signed({1'b0, beep_atten});
  assign spk_beep_gain = $signed({1'b0, spk_gain}) -
                         $signed({1'b0, beep_atten});

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer
  poc_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(wr_en && data_sel),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[PW-1:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fs_tick),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Digital playback path
  function automatic logic signed [W-1:0] poc_sat(
    input logic signed [W+19:0] v
  );
    logic signed [W+19:0] hi, lo;
    hi = (W + 20)'({1'b0, {(W-1){1'b1}}});
    lo = -hi - 1;
    if (v > hi) begin
      poc_sat = hi[W-1:0];
    end else if (v < lo) begin
      poc_sat = lo[W-1:0];
    end else begin
      poc_sat = v[W-1:0];
    end
  endfunction : poc_sat

  function automatic logic signed [W-1:0] poc_deemph(
    input logic signed [W-1:0] x,
    input logic signed [W-1:0] x1,
    input logic signed [W-1:0] y1,
    input logic [1:0] sel
  );
    logic signed [15:0] b0, b1, c;
    logic signed [W+19:0] acc;
    b0 = B0_44K1;
    b1 = B1_44K1;
    c = C_44K1;
    acc = '0;
    if (sel == DEEMPH_48K) begin
      b0 = B0_48K;
      b1 = B1_48K;
      c = C_48K;
    end else if (sel == DEEMPH_32K) begin
      b0 = B0_32K;
      b1 = B1_32K;
      c = C_32K;
    end
    // Widen before multiplying so the products keep their upper bits
    acc = (W + 20)'(b0) * (W + 20)'(x) + (W + 20)'(b1) * (W + 20)'(x1) +
          (W + 20)'(c) * (W + 20)'(y1);
    poc_deemph = poc_sat(acc >>> COEF_FRAC);
  endfunction : poc_deemph

  logic signed [W-1:0] in_l, in_r, mix_l, mix_r, avg, emph_l, emph_r;
  logic signed [W-1:0] out_l, out_r;
  logic signed [W-1:0] x1_l, x1_r, y1_l, y1_r;
  logic signed [W-1:0] next_x1_l, next_x1_r, next_y1_l, next_y1_r;
  logic [W-1:0] next_left, next_right;
  logic next_valid, mute_req;
  logic [15:0] mute_gain;
  logic signed [W+16:0] prod_l, prod_r;

  // Underrun plays silence rather than repeating stale samples
  assign in_l = fifo_out_valid ? $signed(fifo_out_data[W-1:0]) : '0;
  assign in_r = fifo_out_valid ? $signed(fifo_out_data[PW-1:W]) : '0;
  assign avg = W'(($signed({in_l[W-1], in_l}) +
                   $signed({in_r[W-1], in_r})) >>> 1);

  always_comb begin
    case (channel_mix_sel)
      MIX_STEREO: begin
        mix_l = in_l;
        mix_r = in_r;
      end
      MIX_LEFT: begin
        mix_l = in_l;
        mix_r = in_l;
      end
      MIX_RIGHT: begin
        mix_l = in_r;
        mix_r = in_r;
      end
      default: begin
        mix_l = avg;
        mix_r = avg;
      end
    endcase
  end

  assign emph_l = (deemph_select == DEEMPH_OFF) ? mix_l :
                  poc_deemph(mix_l, x1_l, y1_l, deemph_select);
  assign emph_r = (deemph_select == DEEMPH_OFF) ? mix_r :
                  poc_deemph(mix_r, x1_r, y1_r, deemph_select);

  // Ramp is linear in amplitude; full level passes samples untouched
  assign mute_req = soft_mute_ctrl && !auto_level_control;
  assign mute_gain = 16'(mute_level * MUTE_RECIP);
  assign prod_l = emph_l * $signed({1'b0, mute_gain});
  assign prod_r = emph_r * $signed({1'b0, mute_gain});
  assign out_l = (mute_level == MUTE_FULL) ? emph_l : W'(prod_l >>> 16);
  assign out_r = (mute_level == MUTE_FULL) ? emph_r : W'(prod_r >>> 16);

  always_comb begin
    next_mute_level = mute_level;
    next_x1_l = x1_l;
    next_x1_r = x1_r;
    next_y1_l = y1_l;
    next_y1_r = y1_r;
    next_left = left_line_output;
    next_right = right_line_output;
    next_valid = 1'b0;
    if (fs_tick) begin
      if (mute_req && (mute_level != 9'h000)) begin
        next_mute_level = mute_level - 1'b1;
      end else if (!mute_req && (mute_level != MUTE_FULL)) begin
        next_mute_level = mute_level + 1'b1;
      end
      next_x1_l = mix_l;
      next_x1_r = mix_r;
      next_y1_l = emph_l;
      next_y1_r = emph_r;
      next_valid = 1'b1;
      if (line_drive_en && (output_volume_two != VOL_MUTE)) begin
        next_left = out_l;
        next_right = out_r;
      end else begin
        next_left = '0;
        next_right = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_level <= MUTE_FULL;
      x1_l <= '0;
      x1_r <= '0;
      y1_l <= '0;
      y1_r <= '0;
      left_line_output <= '0;
      right_line_output <= '0;
      line_out_valid <= 1'b0;
    end else begin
      mute_level <= next_mute_level;
      x1_l <= next_x1_l;
      x1_r <= next_x1_r;
      y1_l <= next_y1_l;
      y1_r <= next_y1_r;
      left_line_output <= next_left;
      right_line_output <= next_right;
      line_out_valid <= next_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_deemph_bypass;
    @(posedge pclk) disable iff (!presetn)
      fs_tick && (deemph_select == DEEMPH_OFF) && line_drive_en &&
      (mute_level == MUTE_FULL) && (output_volume_two != VOL_MUTE)
      |=> left_line_output == $past(mix_l);
  endproperty
  a_deemph_bypass: assert property (p_deemph_bypass)
    else $error("de-emphasis off but output differs from input");

  property p_mute_down;
    @(posedge pclk) disable iff (!presetn)
      fs_tick && mute_req && (mute_level != 9'h000)
      |=> mute_level == $past(mute_level) - 9'h001;
  endproperty
  a_mute_down: assert property (p_mute_down)
    else $error("soft mute ramp did not step down");

  property p_mute_up;
    @(posedge pclk) disable iff (!presetn)
      fs_tick && !soft_mute_ctrl && (mute_level != MUTE_FULL)
      |=> mute_level == $past(mute_level) + 9'h001;
  endproperty
  a_mute_up: assert property (p_mute_up)
    else $error("soft mute release did not ramp up");

  property p_alc_ignore;
    @(posedge pclk) disable iff (!presetn)
      auto_level_control && fs_tick && (mute_level != MUTE_FULL)
      |=> mute_level > $past(mute_level);
  endproperty
  a_alc_ignore: assert property (p_alc_ignore)
    else $error("soft mute acted during auto level control");

  property p_common_voltage;
    @(posedge pclk) disable iff (!presetn)
      fs_tick && (mono_input_power || !dac_to_lineout)
      |=> (left_line_output == '0) && (right_line_output == '0);
  endproperty
  a_common_voltage: assert property (p_common_voltage)
    else $error("line outputs driven while path disabled");

  property p_lo_rise;
    @(posedge pclk) disable iff (!presetn)
      wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_LOSAVE] &&
      pwdata[CTRL_LOPWR] |=> lineout_mode == POC_LO_SAVE_RISE;
  endproperty
  a_lo_rise: assert property (p_lo_rise)
    else $error("line output mode not power-save rising");

  property p_mix_left;
    @(posedge pclk) disable iff (!presetn)
      fs_tick && (channel_mix_sel == MIX_LEFT)
      |=> left_line_output == right_line_output;
  endproperty
  a_mix_left: assert property (p_mix_left)
    else $error("left-on-both mix gave different channels");

  property p_pullup;
    @(posedge pclk) disable iff (!presetn)
      (lineout_pullup_en || mic_pullup_en) |-> line_share_en &&
      (mic_pullup_en == !adc_power) && (lineout_pullup_en == lineout_save);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("shared line pull-up state wrong");

  property p_mono_pin;
    @(posedge pclk) disable iff (!presetn)
      (beep_spk_route || beep_lo_route) |-> right_line_output_mono_in_mode &&
      !line_drive_en;
  endproperty
  a_mono_pin: assert property (p_mono_pin)
    else $error("beep routed while pin is a line output");

  property p_beep_floor;
    @(posedge pclk) disable iff (!presetn)
      !beep_resistor_mode && (beep_level_sel == 3'h7) &&
      (lineout_gain_sel == 2'h0) |-> lo_beep_gain == -13'sh0FA0;
  endproperty
  a_beep_floor: assert property (p_beep_floor)
    else $error("lowest beep level is not -40 dB");

endmodule : poc_output_ctrl

// *** poc_fs_src.sv ***
`timescale 1ns/100ps
module poc_fs_src (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stall control
  input wire logic run,
  // Sample strobe
  output logic fs_tick
);
  logic [1:0] cnt;
  // Short sample period keeps the full mute ramp within a few thousand cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
      fs_tick <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      fs_tick <= run && cnt == 2'h3;
    end
  end
endmodule : poc_fs_src

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
  import poc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic run = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, d, e;
  logic pready, pslverr, fs_tick, er, vld, drv, lpu, mpu, rmi, bs, bl, bx;
  logic [15:0] lo, ro;
  logic [1:0] gsel;
  logic [7:0] vol2;
  poc_lo_mode_t mode;
  logic [1:0] seq [7] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h0};
  int fail_count = 0;
  int n_compared = 0;
  int seed = 15;
  int n_tick = 0;
  int n_step, exp_lv;

  always #4 pclk = ~pclk;

  // Sample periods seen, so ramp levels can be predicted exactly
  always @(posedge pclk) begin
    if (fs_tick === 1'b1) begin
      n_tick <= n_tick + 1;
    end
  end

  poc_fs_src i_src (.pclk(pclk), .presetn(presetn), .run(run),
    .fs_tick(fs_tick));
  poc_output_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fs_tick(fs_tick),
    .left_line_output(lo), .right_line_output(ro), .line_out_valid(vld),
    .line_drive_en(drv), .lineout_mode(mode), .lineout_gain_sel(gsel),
    .output_volume_two(vol2), .lineout_pullup_en(lpu),
    .mic_pullup_en(mpu), .right_line_output_mono_in_mode(rmi), .beep_spk_route(bs),
    .beep_lo_route(bl), .beep_ext_mode(bx));

  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("fails %0d compares %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_compared++;
    if (got !== ex) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask : chk

  // One idle cycle after each transfer so no strobe is driven twice a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 3000) begin
      fail_count++;
      complete_run();
    end
  endtask : apb

  task automatic pop;
    int n;
    n = 0;
    run <= 1'b1;
    @(posedge pclk);
    while (vld !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    run <= 1'b0;
    if (n >= 100) begin
      fail_count++;
      complete_run();
    end
  endtask : pop

  task automatic lvl(input int c, input logic [8:0] ex);
    repeat (c) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("mute level", {23'h0, ex}, {23'h0, rd[8:0]});
  endtask : lvl

  // Runs the strobe source for c cycles, then lets it go quiet
  task automatic steps(input int c);
    int t0;
    t0 = n_tick;
    run <= 1'b1;
    repeat (c) @(posedge pclk);
    run <= 1'b0;
    repeat (6) @(posedge pclk);
    n_step = n_tick - t0;
  endtask : steps

  function automatic logic [15:0] ramp_exp(input logic [15:0] x,
      input int lv);
    longint p;
    p = longint'($signed(x)) * longint'(MUTE_RECIP) * lv;
    ramp_exp = p[31:16];
  endfunction : ramp_exp

  function automatic logic [31:0] mix_exp(input logic [1:0] m,
      input logic [31:0] v);
    logic [16:0] s;
    s = {v[15], v[15:0]} + {v[31], v[31:16]};
    case (m)
      2'h0: mix_exp = v;
      2'h1: mix_exp = {v[15:0], v[15:0]};
      2'h2: mix_exp = {v[31:16], v[31:16]};
      default: mix_exp = {s[16:1], s[16:1]};
    endcase
  endfunction : mix_exp

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    lvl(0, 9'h1B9);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ADDR_CTRL, {25'h0, seq[i][0], seq[i][1], 5'h11});
      chk("mode", {30'h0, seq[i]}, {30'h0, mode});
      chk("drive", {31'h0, seq[i][0]}, {31'h0, drv});
    end
    apb(1'b1, ADDR_VOL, 32'h1F91);
    chk("gain sel", 32'h3, {30'h0, gsel});
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, ADDR_CTRL, v ? 32'h74F1 : 32'h51);
      chk("pullups", {30'h0, {2{v[0]}}}, {30'h0, lpu, mpu});
      chk("mono pin", {31'h0, v[0]}, {31'h0, rmi});
      chk("beep routes", {30'h0, {2{v[0]}}}, {30'h0, bs, bl});
      chk("beep mode", {31'h0, v[0]}, {31'h0, bx});
      chk("drive mono", {31'h0, !v[0]}, {31'h0, drv});
      apb(1'b0, ADDR_GAIN, 32'h0);
      chk("beep gain", v ? 32'h0262014E : 32'h12C211AE, rd);
    end
    for (int m = 0; m < 4; m++) begin
      d = (m == 3) ? 32'h7FFF7FFF : $random(seed);
      apb(1'b1, ADDR_CTRL, {22'h0, m[1:0], 8'h51});
      apb(1'b1, ADDR_DATA, d);
      pop();
      chk("mix", mix_exp(m[1:0], d), {ro, lo});
    end
    apb(1'b1, ADDR_CTRL, 32'h41);
    apb(1'b1, ADDR_DATA, 32'h12345678);
    pop();
    chk("common level", 32'h0, {ro, lo});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_DATA, $random(seed));
    end
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("full", 32'h1, {31'h0, rd[12]});
    fork
      apb(1'b1, ADDR_DATA, 32'h0);
      begin
        repeat (30) @(posedge pclk);
        run <= 1'b1;
      end
    join
    repeat (40) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("drained", 32'h0, {31'h0, rd[13]});
    run <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h5D);
    steps(400);
    lvl(0, MUTE_FULL);
    apb(1'b1, ADDR_CTRL, 32'h55);
    steps(200);
    exp_lv = MUTE_STEPS_INT - n_step;
    lvl(0, 9'(exp_lv));
    d = $random(seed);
    apb(1'b1, ADDR_DATA, d);
    pop();
    e = {ramp_exp(d[31:16], exp_lv), ramp_exp(d[15:0], exp_lv)};
    chk("ramp sample", e, {ro, lo});
    exp_lv = exp_lv - 1;
    apb(1'b1, ADDR_CTRL, 32'h5D);
    steps(100);
    exp_lv = exp_lv + n_step;
    lvl(0, 9'(exp_lv));
    apb(1'b1, ADDR_CTRL, 32'h55);
    steps(100);
    exp_lv = exp_lv - n_step;
    lvl(0, 9'(exp_lv));
    apb(1'b1, ADDR_CTRL, 32'h51);
    steps(100);
    exp_lv = exp_lv + n_step;
    lvl(0, 9'(exp_lv));
    steps(2000);
    lvl(0, MUTE_FULL);
    apb(1'b1, ADDR_CTRL, 32'h55);
    steps(2000);
    lvl(0, 9'h000);
    chk("silent flag", 32'h1, {31'h0, rd[14]});
    apb(1'b1, ADDR_DATA, d);
    pop();
    chk("muted sample", 32'h0, {ro, lo});
    complete_run();
  end
endmodule : tb
